// [hw/stpsc_oc_counter.v]
// Overcurrent error counter with 63-cycle lockout window for one bridge or the high side.
`timescale 1ns/1ps
`default_nettype none
`include "stpsc_regs.vh"
module stpsc_oc_counter (
    input  wire       mclk_in,
    input  wire       rstn_in,
    input  wire       clear_in,
    input  wire       pwm_start_in,
    input  wire       oc_event_in,
    output reg        flag_out
);
    reg [1:0] err_reg;
    reg [5:0] quiet_reg;
    reg [5:0] lock_reg;

    ////////////////////////////////////////////////////////////////////////
    // Count overcurrent cycles; three of them lock the bridge for 63 cycles.
    // An event in the cycle of a clear is not lost: the count restarts at one.
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            err_reg   <= 2'h0;
            quiet_reg <= 6'h0;
            lock_reg  <= 6'h0;
            flag_out  <= 1'b0;
        end else if (clear_in) begin
            err_reg   <= (pwm_start_in && oc_event_in) ? 2'h1 : 2'h0;
            quiet_reg <= 6'h0;
            lock_reg  <= 6'h0;
            flag_out  <= 1'b0;
        end else if (pwm_start_in) begin
            if (lock_reg != 6'h0) begin
                lock_reg <= lock_reg - 6'h1;
                if (lock_reg == 6'h1) flag_out <= 1'b0;
            end else if (oc_event_in) begin
                quiet_reg <= 6'h0;
                if (err_reg + 2'h1 == `STPSC_OC_TRIP_COUNT) begin // [R10] [R21]
                    err_reg  <= 2'h0;
                    lock_reg <= `STPSC_OC_WINDOW;
                    flag_out <= 1'b1;
                end else begin
                    err_reg <= err_reg + 2'h1;
                end
            end else if (quiet_reg == `STPSC_OC_WINDOW) begin
                err_reg <= 2'h0; // More than 63 clean cycles forget old errors.
            end else begin
                quiet_reg <= quiet_reg + 6'h1;
            end
        end
    end
endmodule // stpsc_oc_counter
`default_nettype wire

// [hw/stpsc_open_load.v]
// Open-load watchdog for one bridge: oscillator cycles without a PWM switch-off.
`timescale 1ns/1ps
`default_nettype none
`include "stpsc_regs.vh"
module stpsc_open_load (
    input  wire       mclk_in,
    input  wire       rstn_in,
    input  wire       clear_in,
    input  wire       chop_off_in,
    input  wire       osc_tick_in,
    input  wire       switch_off_in,
    input  wire       fault_in,
    output reg        flag_out
);
    reg [3:0] cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // A zero current code parks the chopper, so the flag is held clear.
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg  <= 4'h0;
            flag_out <= 1'b0;
        end else if (clear_in || chop_off_in) begin
            cnt_reg  <= 4'h0;
            flag_out <= 1'b0; // [R12]
        end else begin
            if (switch_off_in) cnt_reg <= 4'h0;
            else if (osc_tick_in && cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
            flag_out <= fault_in || (cnt_reg > `STPSC_OL_LIMIT); // [R11] [R13]
        end
    end
endmodule // stpsc_open_load
`default_nettype wire

// [hw/stpsc_regs.vh]
// Constants of the stepper serial control block: field positions, reset values and counts.
`ifndef STPSC_REGS_VH
`define STPSC_REGS_VH
`define STPSC_WORD_W          12
`define STPSC_CMD_RESET       12'h000
`define STPSC_CMD_MDA_BIT     11
`define STPSC_CMD_CA_MSB      10
`define STPSC_CMD_CA_LSB      7
`define STPSC_CMD_PHA_BIT     6
`define STPSC_CMD_MDB_BIT     5
`define STPSC_CMD_CB_MSB      4
`define STPSC_CMD_CB_LSB      1
`define STPSC_CMD_PHB_BIT     0
`define STPSC_ST_LD_MSB       11
`define STPSC_ST_LD_LSB       9
`define STPSC_ST_ONE_BIT      8
`define STPSC_ST_OT_BIT       7
`define STPSC_ST_TEMP_PREWARNING_FLAG_BIT     6
`define STPSC_ST_UV_BIT       5
`define STPSC_ST_HIGH_SIDE_OVERCURRENT_FLAG_BIT     4
`define STPSC_ST_OLB_BIT      3
`define STPSC_ST_OLA_BIT      2
`define STPSC_ST_OCB_BIT      1
`define STPSC_ST_OCA_BIT      0
`define STPSC_CUR_ZERO        4'h0
`define STPSC_OC_TRIP_COUNT   2'h3
`define STPSC_OC_WINDOW       6'h3f
`define STPSC_OL_LIMIT        4'he
`endif

// [hw/stpsc_top.v]
// Serial control, command decode and diagnostics of the dual-bridge stepper driver.
//
// Overview of operation
// [R1] One 12-bit word per microstep, MSB first.
// [R2] Bit 11 mixed decay A; bits 10..7 current A.
// [R3] Bit 6 sets coil A polarity.
// [R4] Bit 5 decay B, bits 4..1 current, bit 0 polarity.
// [R5] Current codes scale linearly like 4-bit DAC.
// [R6] Code zero keeps bridge in slow decay.
// [R7] Both codes zero: clear overcurrent, enter standby.
// [R8] Status word MSB first, bits 11..9 load.
// [R9] Bit 8 one; temperature and undervoltage flags.
// [R10] Overcurrent flags after 3 within 63 cycles.
// [R11] Open load after 14 cycles without switch-off.
// [R12] Zero current code forces open load flag low.
// [R13] Faults also raise the open load flags.
// [R14] Host reads open load at low speed.
// [R15] Reset or disable clears registers, standby.
// [R16] Low enable runs device; high disables it.
// [R17] Serial mode select high enables serial control.
// [R18] Low reference select picks external analog references.
// [R19] Serial data output is tri-state.
// [R20] Disable in serial mode holds interface reset.
// [R21] Separate overcurrent counters with 63-cycle lockout.
// [R22] Shift during chip select low; apply on rise.
// [R23] Data output driven only while chip select low.
`timescale 1ns/1ps
`default_nettype none
`include "stpsc_regs.vh"
module stpsc_top (
    // Clock and reset.
    input  wire        mclk_in,
    input  wire        rstn_in,

    // Serial pins; inputs asynchronous, outputs on this clock.
    input  wire        sck_in,
    input  wire        sdi_in,
    input  wire        csn_in,
    output reg         sdo_out,
    output reg         sdo_oe_out,

    // Mode pins, asynchronous levels.
    input  wire        enable_n_in,
    input  wire        serial_mode_select_in,
    input  wire        analog_reference_select_n_in,

    // Status levels on this clock.
    input  wire [2:0]  load_level_in,
    input  wire        over_temp_in,
    input  wire        temp_prewarning_in,
    input  wire        undervoltage_in,

    // Chopper pulses on this clock.
    input  wire        osc_tick_in,
    input  wire        pwm_start_in,
    input  wire        switch_off_a_in,
    input  wire        switch_off_b_in,
    input  wire        overcurrent_a_in,
    input  wire        overcurrent_b_in,
    input  wire        high_side_overcurrent_in,

    // Applied command fields.
    output reg         mixed_decay_a_out,
    output reg  [3:0]  coil_a_current_out,
    output reg         polarity_a_out,
    output reg         mixed_decay_b_out,
    output reg  [3:0]  coil_b_current_out,
    output reg         polarity_b_out,

    // Bridge and power controls.
    output reg         bridge_a_off_out,
    output reg         bridge_b_off_out,
    output reg         use_external_ref_out,
    output reg         standby_out,
    output reg         shutdown_out
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic reads a serial or mode pin.
    // Stage one is read only by stage two.
    reg [1:0] sck_sync_reg;
    reg [1:0] sdi_sync_reg;
    reg [1:0] csn_sync_reg;
    reg [1:0] enn_sync_reg;
    reg [1:0] spe_sync_reg;
    reg [1:0] ann_sync_reg;
    reg       sck_prev_reg;
    reg       csn_prev_reg;

    // Edge detectors reset to each pin's idle level,
    // so leaving reset never shows a false edge.

    // Pins come from the host's clock domain, so each gets a plain two-flop chain.
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
            csn_sync_reg <= 2'h3;
            enn_sync_reg <= 2'h3;
            spe_sync_reg <= 2'h0;
            ann_sync_reg <= 2'h3;
            sck_prev_reg <= 1'b0;
            csn_prev_reg <= 1'b1;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], sck_in};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_in};
            csn_sync_reg <= {csn_sync_reg[0], csn_in};
            enn_sync_reg <= {enn_sync_reg[0], enable_n_in};
            spe_sync_reg <= {spe_sync_reg[0], serial_mode_select_in};
            ann_sync_reg <= {ann_sync_reg[0], analog_reference_select_n_in};
            sck_prev_reg <= sck_sync_reg[1];
            csn_prev_reg <= csn_sync_reg[1];
        end
    end

    // Synchronised levels and their edges.
    // Each serial clock phase must last two
    // system cycles, or an edge is lost.
    wire sck_s    = sck_sync_reg[1];
    wire csn_s    = csn_sync_reg[1];
    wire disabled = enn_sync_reg[1];          // [R16]
    wire serial   = spe_sync_reg[1];          // [R17]
    wire sck_rise = sck_s && !sck_prev_reg;
    wire sck_fall = !sck_s && sck_prev_reg;
    wire cs_rise  = csn_s && !csn_prev_reg;
    // Interface is held in reset while disabled or outside serial mode.
    wire if_reset = disabled || !serial;      // [R15] [R20]

    ////////////////////////////////////////////////////////////////////////
    // Shift registers and the applied command word.
    // Command bits, first bit on top.
    reg [11:0] rx_reg;
    // Status bits, top bit on the pin.
    reg [11:0] tx_reg;
    // Rising clock edges in this frame.
    reg [3:0]  bit_cnt_reg;
    // The applied command word.
    reg [11:0] cmd_reg;
    // Overcurrent clear: one cycle per standby word, held high through interface reset.
    reg        oc_clear_reg;

    // Codes of the word now received.
    wire [3:0] rx_cur_a = rx_reg[`STPSC_CMD_CA_MSB:`STPSC_CMD_CA_LSB];
    wire [3:0] rx_cur_b = rx_reg[`STPSC_CMD_CB_MSB:`STPSC_CMD_CB_LSB];
    // Exactly twelve edges make a word.
    wire       word_done = cs_rise && (bit_cnt_reg == 4'hc);

    // Protection flags.
    wire oc_a_flag;
    wire oc_b_flag;
    wire oc_hs_flag;
    wire ol_a_flag;
    wire ol_b_flag;

    // Status snapshot taken when chip select falls; bit 8 is constant one.
    wire [11:0] status_word = {load_level_in, 1'b1, over_temp_in,     // [R8] [R9]
                               temp_prewarning_in, undervoltage_in, oc_hs_flag,
                               ol_b_flag, ol_a_flag, oc_b_flag, oc_a_flag}; // [R10] [R11]

    // Sample SDI on SCK rising, shift status on falling edge. Only a complete
    // 12-bit frame is applied, so a glitched frame cannot move the coils.
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_reg       <= 12'h000;
            tx_reg       <= 12'h000;
            bit_cnt_reg  <= 4'h0;
            cmd_reg      <= `STPSC_CMD_RESET;
            oc_clear_reg <= 1'b0;
        end else if (if_reset) begin
            rx_reg       <= 12'h000;
            tx_reg       <= 12'h000;
            bit_cnt_reg  <= 4'h0;
            // Disable clears the word and the flags.
            cmd_reg      <= `STPSC_CMD_RESET;               // [R15]
            oc_clear_reg <= 1'b1;
        end else begin
            oc_clear_reg <= 1'b0;
            // Chip select fall: snapshot and restart.
            if (csn_prev_reg && !csn_s) begin
                tx_reg      <= status_word;
                bit_cnt_reg <= 4'h0;
            end else if (!csn_s && sck_rise) begin
                // Data comes from the last stage, in step with the clock.
                rx_reg <= {rx_reg[10:0], sdi_sync_reg[1]};   // [R1] [R22]
                if (bit_cnt_reg != 4'hf) bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (!csn_s && sck_fall) begin
                // Extra clocks shift out zeros.
                tx_reg <= {tx_reg[10:0], 1'b0};
            end
            // A short or long frame is dropped whole.
            if (word_done) begin
                cmd_reg <= rx_reg;                           // [R1] [R22]
                if (rx_cur_a == `STPSC_CUR_ZERO && rx_cur_b == `STPSC_CUR_ZERO)
                    oc_clear_reg <= 1'b1;                    // [R7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection counters and open-load watchdogs.
    // A standby word or a disable clears all three counters.
    // Bridge A low side.
    stpsc_oc_counter u_oc_a (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .clear_in     (oc_clear_reg),
        .pwm_start_in (pwm_start_in),
        .oc_event_in  (overcurrent_a_in),
        .flag_out     (oc_a_flag)
    );

    // Bridge B low side.
    stpsc_oc_counter u_oc_b (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .clear_in     (oc_clear_reg),
        .pwm_start_in (pwm_start_in),
        .oc_event_in  (overcurrent_b_in),
        .flag_out     (oc_b_flag)
    );

    // High side; a trip stops both bridges.
    stpsc_oc_counter u_oc_hs (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .clear_in     (oc_clear_reg),
        .pwm_start_in (pwm_start_in),
        .oc_event_in  (high_side_overcurrent_in),
        .flag_out     (oc_hs_flag)
    );

    // Applied codes; faults raise open load.
    wire [3:0] cur_a = cmd_reg[`STPSC_CMD_CA_MSB:`STPSC_CMD_CA_LSB];
    wire [3:0] cur_b = cmd_reg[`STPSC_CMD_CB_MSB:`STPSC_CMD_CB_LSB];
    wire       fault = over_temp_in || undervoltage_in || oc_hs_flag;

    // Bridge A watchdog.
    stpsc_open_load u_ol_a (
        .mclk_in       (mclk_in),
        .rstn_in       (rstn_in),
        .clear_in      (if_reset),
        .chop_off_in   (cur_a == `STPSC_CUR_ZERO),           // [R12]
        .osc_tick_in   (osc_tick_in),
        .switch_off_in (switch_off_a_in),
        .fault_in      (fault || oc_a_flag),                 // [R13]
        .flag_out      (ol_a_flag)
    );

    // Bridge B watchdog.
    stpsc_open_load u_ol_b (
        .mclk_in       (mclk_in),
        .rstn_in       (rstn_in),
        .clear_in      (if_reset),
        .chop_off_in   (cur_b == `STPSC_CUR_ZERO),           // [R12]
        .osc_tick_in   (osc_tick_in),
        .switch_off_in (switch_off_b_in),
        .fault_in      (fault || oc_b_flag),                 // [R13]
        .flag_out      (ol_b_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs to the bridges, DAC and the serial data pin.
    // Current codes go to the analog DAC unchanged; it steps code/16 linearly.
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mixed_decay_a_out    <= 1'b0;
            coil_a_current_out   <= 4'h0;
            polarity_a_out       <= 1'b0;
            mixed_decay_b_out    <= 1'b0;
            coil_b_current_out   <= 4'h0;
            polarity_b_out       <= 1'b0;
            // Bridges start off, device in standby.
            bridge_a_off_out     <= 1'b1;
            bridge_b_off_out     <= 1'b1;
            use_external_ref_out <= 1'b0;
            standby_out          <= 1'b1;
            shutdown_out         <= 1'b0;
            sdo_out              <= 1'b0;
            sdo_oe_out           <= 1'b0;
        end else begin
            // Command fields follow the word.
            mixed_decay_a_out    <= cmd_reg[`STPSC_CMD_MDA_BIT];     // [R2]
            coil_a_current_out   <= cur_a;                           // [R2] [R5]
            polarity_a_out       <= cmd_reg[`STPSC_CMD_PHA_BIT];     // [R3]
            mixed_decay_b_out    <= cmd_reg[`STPSC_CMD_MDB_BIT];     // [R4]
            coil_b_current_out   <= cur_b;                           // [R4] [R5]
            polarity_b_out       <= cmd_reg[`STPSC_CMD_PHB_BIT];     // [R4]

            // Zero code or locked bridge keeps the bridge off in slow decay.
            bridge_a_off_out     <= (cur_a == `STPSC_CUR_ZERO) || oc_a_flag || oc_hs_flag
                                    || over_temp_in;                 // [R6] [R21]
            bridge_b_off_out     <= (cur_b == `STPSC_CUR_ZERO) || oc_b_flag || oc_hs_flag
                                    || over_temp_in;                 // [R6] [R21]

            // Reference select, power state, data pin.
            use_external_ref_out <= serial && !ann_sync_reg[1];      // [R18]
            // Standby follows the cleared word, so it
            // never leads the currents switching off.
            standby_out          <= (cur_a == `STPSC_CUR_ZERO) &&
                                    (cur_b == `STPSC_CUR_ZERO);      // [R7] [R15]
            shutdown_out         <= serial && disabled;              // [R20]
            sdo_out              <= tx_reg[11];                      // [R8]
            sdo_oe_out           <= !csn_s && !if_reset;             // [R19] [R23]
        end
    end
endmodule // stpsc_top
`default_nettype wire

// [sim/stpsc_host_model.sv]
// Host controller model: a mode 0 serial master that sends commands and collects status.
`timescale 1ns/1ps
`default_nettype none
module stpsc_host_model (
    input  wire logic mclk_in,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in,
    output var logic  sck_out,
    output var logic  sdi_out,
    output var logic  csn_out
);
    // Serial clock idles low; it only runs inside frames.
    initial begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
        csn_out = 1'b1;
    end
    ////////////////////////////////////////
    // One frame; 200 ns serial period, four system cycles per half.
    // Status is sampled late in the high phase, long after the falling-edge update.
    task automatic frame(input logic [11:0] cmd, input int nbits, output logic [11:0] st);
        int i;
        st = 12'h000;
        @(negedge mclk_in);
        csn_out = 1'b0;
        repeat (12) @(negedge mclk_in);
        for (i = 0; i < nbits; i++) begin
            sdi_out = (i < 12) ? cmd[11 - i] : 1'b0;
            repeat (4) @(negedge mclk_in);
            sck_out = 1'b1;
            repeat (3) @(negedge mclk_in);
            if (i < 12) st[11 - i] = sdo_oe_in ? sdo_in : ~sdo_in;
            @(negedge mclk_in);
            sck_out = 1'b0;
        end
        repeat (4) @(negedge mclk_in);
        csn_out = 1'b1;
        sdi_out = ~sdi_out;
        repeat (4) @(negedge mclk_in);
    endtask
endmodule // stpsc_host_model
`default_nettype wire

// [sim/stpsc_monitor.sv]
// Concurrent checks on the ports of the stepper serial control block.
`timescale 1ns/1ps
`default_nettype none
module stpsc_monitor (
    input wire logic       mclk_in,
    input wire logic       rstn_in,
    input wire logic       csn_in,
    input wire logic       enable_n_in,
    input wire logic       serial_mode_select_in,
    input wire logic       analog_reference_select_n_in,
    input wire logic       sdo_oe_out,
    input wire logic       shutdown_out,
    input wire logic       standby_out,
    input wire logic       use_external_ref_out,
    input wire logic       mixed_decay_a_out,
    input wire logic [3:0] coil_a_current_out,
    input wire logic       polarity_a_out,
    input wire logic       mixed_decay_b_out,
    input wire logic [3:0] coil_b_current_out,
    input wire logic       polarity_b_out
);
    // All checks share the one clock; reset masks them.
    default clocking cb_main @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    wire [11:0] cmd_w = {mixed_decay_a_out, coil_a_current_out, polarity_a_out,
                         mixed_decay_b_out, coil_b_current_out, polarity_b_out};
    ////////////////////////////////////////
    // Six cycles cover the two-flop synchroniser plus the output register.
    sequence s_cs_idle;
        csn_in [*6];
    endsequence
    sequence s_disabled;
        enable_n_in [*6];
    endsequence
    property p_oe_idle; s_cs_idle |-> !sdo_oe_out; endproperty
    sequence s_shut_req;
        (enable_n_in && serial_mode_select_in) [*6];
    endsequence
    property p_shut; s_shut_req |-> shutdown_out; endproperty
    property p_dis_clear; s_disabled |-> cmd_w == 12'h000 && standby_out; endproperty
    property p_dis_oe; s_disabled |-> !sdo_oe_out; endproperty
    property p_standby; standby_out |-> coil_a_current_out == 4'h0 && coil_b_current_out == 4'h0; endproperty
    property p_ext; (serial_mode_select_in && !analog_reference_select_n_in) [*6] |-> use_external_ref_out; endproperty
    property p_hold; (!csn_in && !enable_n_in && serial_mode_select_in) [*8] |=> $stable(cmd_w); endproperty
    property p_oe_mode; (!serial_mode_select_in) [*6] |-> !sdo_oe_out; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data output driven while deselected");
    a_shut: assert property (p_shut) else $error("no shutdown while disabled");
    a_dis_clear: assert property (p_dis_clear) else $error("command not cleared by disable");
    a_dis_oe: assert property (p_dis_oe) else $error("data output driven while disabled");
    a_standby: assert property (p_standby) else $error("standby with a coil current set");
    a_ext: assert property (p_ext) else $error("external reference not selected");
    a_hold: assert property (p_hold) else $error("command changed inside a frame");
    a_oe_mode: assert property (p_oe_mode) else $error("data output driven outside serial mode");
endmodule // stpsc_monitor
bind stpsc_top stpsc_monitor u_mon (.mclk_in(mclk_in), .rstn_in(rstn_in), .csn_in(csn_in),
    .enable_n_in(enable_n_in), .serial_mode_select_in(serial_mode_select_in),
    .analog_reference_select_n_in(analog_reference_select_n_in), .sdo_oe_out(sdo_oe_out),
    .shutdown_out(shutdown_out), .standby_out(standby_out), .use_external_ref_out(use_external_ref_out),
    .mixed_decay_a_out(mixed_decay_a_out), .coil_a_current_out(coil_a_current_out),
    .polarity_a_out(polarity_a_out), .mixed_decay_b_out(mixed_decay_b_out),
    .coil_b_current_out(coil_b_current_out), .polarity_b_out(polarity_b_out));
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking testbench of the stepper serial control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       mclk_in, rstn_in, enable_n, serial, analog_reference_select_n, osc, pwm, swa, swb, overcurrent_a, overcurrent_b, high_side_overcurrent_flag, ot, pw, uv;
    logic [2:0] ld;
    logic [11:0] st;
    wire        sck, sdi, csn, sdo, sdo_oe, mixed_decay_a, polarity_a, mixed_decay_b, polarity_b, boa, bob, ext, stby, shut;
    wire [3:0]  ca, cb;
    wire [11:0] cmd_seen = {mixed_decay_a, ca, polarity_a, mixed_decay_b, cb, polarity_b};
    int         n_mismatch = 0;
    int         samples_checked = 0;

    stpsc_host_model u_host (.mclk_in(mclk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .sck_out(sck),
        .sdi_out(sdi), .csn_out(csn));
    stpsc_top dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .sck_in(sck), .sdi_in(sdi), .csn_in(csn),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .enable_n_in(enable_n), .serial_mode_select_in(serial),
        .analog_reference_select_n_in(analog_reference_select_n), .load_level_in(ld), .over_temp_in(ot),
        .temp_prewarning_in(pw), .undervoltage_in(uv), .osc_tick_in(osc), .pwm_start_in(pwm),
        .switch_off_a_in(swa), .switch_off_b_in(swb), .overcurrent_a_in(overcurrent_a), .overcurrent_b_in(overcurrent_b),
        .high_side_overcurrent_in(high_side_overcurrent_flag), .mixed_decay_a_out(mixed_decay_a), .coil_a_current_out(ca),
        .polarity_a_out(polarity_a), .mixed_decay_b_out(mixed_decay_b), .coil_b_current_out(cb), .polarity_b_out(polarity_b),
        .bridge_a_off_out(boa), .bridge_b_off_out(bob), .use_external_ref_out(ext),
        .standby_out(stby), .shutdown_out(shut));
    ////////////////////////////////////////
    // Clock, and helpers shared by the scenarios.
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        repeat (8) @(negedge mclk_in);
    endtask
    task automatic tick(input int n, input logic is_pwm);
        repeat (n) begin
            @(negedge mclk_in);
            if (is_pwm) pwm = 1'b1; else osc = 1'b1;
            @(negedge mclk_in);
            pwm = 1'b0;
            osc = 1'b0;
            repeat (2) @(negedge mclk_in);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // Scenarios.
    task automatic t_fields;
        logic [11:0] w [5] = '{12'h801, 12'h7c0, 12'h03e, 12'h041, 12'hfff};
        foreach (w[i]) begin
            u_host.frame(w[i], 12, st);
            settle();
            chk(cmd_seen, w[i]);
            chk(st, 12'hb40);
        end
        {ot, uv} = 2'b11;
        settle();
        u_host.frame(12'hfff, 12, st);
        chk(st, 12'hbec);
        {ot, uv, pw} = 3'b000;
    endtask
    task automatic t_bits;
        u_host.frame(12'h5a5, 11, st);
        settle();
        chk(cmd_seen, 12'hfff);
        u_host.frame(12'h5a5, 13, st);
        settle();
        chk(cmd_seen, 12'hfff);
    endtask
    // Open load is judged at standstill, with no new steps meanwhile.
    task automatic t_open;
        u_host.frame(12'h080, 12, st);
        tick(14, 1'b0);
        u_host.frame(12'h080, 12, st);
        chk(st, 12'hb00);
        tick(1, 1'b0);
        u_host.frame(12'h080, 12, st);
        chk(st, 12'hb04);
        swa = 1'b1;
        @(negedge mclk_in);
        swa = 1'b0;
        u_host.frame(12'h080, 12, st);
        chk(st, 12'hb00);
    endtask
    task automatic t_oc;
        {overcurrent_a, overcurrent_b, high_side_overcurrent_flag} = 3'b111;
        tick(2, 1'b1);
        u_host.frame(12'h080, 12, st);
        chk(st, 12'hb00);
        tick(1, 1'b1);
        {overcurrent_a, overcurrent_b, high_side_overcurrent_flag} = 3'b000;
        u_host.frame(12'h080, 12, st);
        chk(st, 12'hb17);
        chk({boa, bob}, 2'h3);
        u_host.frame(12'h000, 12, st);
        settle();
        chk(stby, 1'b1);
        u_host.frame(12'h000, 12, st);
        chk(st, 12'hb00);
    endtask
    task automatic t_dis;
        analog_reference_select_n = 1'b0;
        settle();
        chk(ext, 1'b1);
        analog_reference_select_n = 1'b1;
        u_host.frame(12'h3c7, 12, st);
        chk(cmd_seen, 12'h3c7);
        enable_n = 1'b1;
        settle();
        chk(cmd_seen, 12'h000);
        chk({shut, stby}, 2'h3);
        u_host.frame(12'h801, 12, st);
        chk(cmd_seen, 12'h000);
        enable_n = 1'b0;
        serial = 1'b0;
        u_host.frame(12'h801, 12, st);
        chk(cmd_seen, 12'h000);
        serial = 1'b1;
        settle();
        u_host.frame(12'h801, 12, st);
        settle();
        chk(cmd_seen, 12'h801);
        chk(shut, 1'b0);
    endtask
    ////////////////////////////////////////
    // Main sequence; the serial select starts high for serial control and t_dis drops it for one frame.
    initial begin
        {rstn_in, enable_n, serial, analog_reference_select_n, osc, pwm, swa, swb, overcurrent_a, overcurrent_b, high_side_overcurrent_flag, ot, uv} = 13'h0600;
        pw = 1'b1;
        ld = 3'h5;
        repeat (12) @(negedge mclk_in);
        rstn_in = 1'b1;
        settle();
        chk(cmd_seen, 12'h000);
        chk({stby, boa, bob, shut, sdo_oe}, 5'h1c);
        t_fields();
        t_bits();
        t_open();
        t_oc();
        t_dis();
        test_done();
    end
    // A hang counts as a mismatch.
    initial begin
        #2000000;
        n_mismatch++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
